// *** design/vector_upper_state_tracker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "upper_state_map.svh"
// Notes on behaviour
// - one of clean, modified, preserved states
// - reset gives clean state, uppers zero
// - three-operand op writes upper, goes modified
// - legacy ops leave upper bits untouched
// - narrow three-operand op zeroes destination upper
// - sources unmodified, only destination written
// - preserved means upper unrelated, nonzero
// - transitions carry penalty types A to D
// - transitions identical across variants
// - baseline pays A and B every time
// - merge variant saves only destination upper
// - upper-clear zeroes all uppers, baseline pays D from preserved
// - upper-clear returns to clean state
// - dirty restore preserved, clean restore clean
module vector_upper_state_tracker
(
	input  wire logic          clk_sys,
	input  wire logic          rstn,
	input  wire logic          merge_variant,
	input  wire logic          op_valid,
	input  wire logic [2:0]    op_kind,
	input  wire logic [3:0]    op_dest,
	input  wire logic [3:0]    op_src_a,
	input  wire logic [3:0]    op_src_b,
	input  wire logic [127:0]  op_upper,
	input  wire logic          restore_dirty,
	output logic [1:0]         state,
	output logic               penalty_valid,
	output logic [2:0]         penalty_type,
	output logic               dep_valid,
	output logic [3:0]         dep_reg,
	output logic               full_copy,
	output logic [15:0]        upper_nonzero
);
	// ****************************************
	// reset release
	// ****************************************
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ****************************************
	// upper bank
	// ****************************************
	upper_if u ();
	upper_bank bank_i
	(
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.u       (u)
	);
	assign upper_nonzero = u.nonzero;

	// ****************************************
	// state machine
	// ****************************************
	upper_state_pkg::upper_state_t cur;
	upper_state_pkg::upper_state_t next_cur;
	logic [2:0]  next_pen;
	logic        next_dep;
	logic        next_copy;
	logic        next_pulse;
	logic [3:0]  next_dep_reg;
	logic        is_op;
	upper_state_pkg::op_kind_t kind;

	assign kind  = upper_state_pkg::op_kind_t'(op_kind);
	assign is_op = op_valid;

	always_comb
	begin
		next_cur  = cur;
		next_pen  = `PEN_NONE;
		next_dep  = 1'b0;
		next_copy = 1'b0;
		next_dep_reg = op_dest;
		u.wr        = 1'b0;
		u.idx       = op_dest;
		u.data      = '0;
		u.clear_all = 1'b0;
		if (is_op)
		begin
			unique case (kind)
				upper_state_pkg::OP_LEGACY:
				begin
					if (cur == upper_state_pkg::ST_MODIFIED)
					begin
						next_cur = upper_state_pkg::ST_PRESERVED;
						next_pen = `PEN_A;
						if (merge_variant)
							next_dep = 1'b1;
						else
							next_copy = 1'b1;
					end
				end
				upper_state_pkg::OP_NARROW3, upper_state_pkg::OP_WIDE3:
				begin
					u.wr = 1'b1;
					u.data = (kind == upper_state_pkg::OP_WIDE3)
						? op_upper : '0;
					if (cur == upper_state_pkg::ST_PRESERVED && !merge_variant)
					begin
						next_pen  = `PEN_B;
						next_copy = 1'b1;
					end
					next_cur = upper_state_pkg::ST_MODIFIED;
				end
				upper_state_pkg::OP_UPCLEAR:
				begin
					u.clear_all = 1'b1;
					if (cur == upper_state_pkg::ST_PRESERVED && !merge_variant)
						next_pen = `PEN_D;
					next_cur = upper_state_pkg::ST_CLEAN;
				end
				upper_state_pkg::OP_RESTORE:
				begin
					if (restore_dirty)
					begin
						next_cur = upper_state_pkg::ST_PRESERVED;
						next_pen = `PEN_C;
					end
					else
					begin
						next_cur = upper_state_pkg::ST_CLEAN;
						u.clear_all = 1'b1;
					end
				end
				default:
				begin
					next_cur = cur;
				end
			endcase
		end
		next_pulse = (next_pen != `PEN_NONE);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur           <= upper_state_pkg::ST_CLEAN;
			penalty_type  <= `PEN_NONE;
			penalty_valid <= 1'b0;
			dep_valid     <= 1'b0;
			dep_reg       <= 4'h0;
			full_copy     <= 1'b0;
		end
		else
		begin
			cur           <= next_cur;
			penalty_type  <= next_pen;
			penalty_valid <= next_pulse;
			dep_valid     <= next_dep;
			dep_reg       <= next_dep_reg;
			full_copy     <= next_copy;
		end
	end
	assign state = cur;

	// ****************************************
	// checks
	// ****************************************
	legal_state_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cur != 2'h3) else $error("illegal tracker state");
	legacy_dirty_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		op_valid && kind == upper_state_pkg::OP_LEGACY
		&& cur == upper_state_pkg::ST_MODIFIED
		|=> cur == upper_state_pkg::ST_PRESERVED && penalty_valid
		&& penalty_type == `PEN_A) else $error("legacy from dirty wrong");
	three_op_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		op_valid && (kind == upper_state_pkg::OP_NARROW3
		|| kind == upper_state_pkg::OP_WIDE3)
		|=> cur == upper_state_pkg::ST_MODIFIED)
		else $error("three-operand not modified");
	narrow_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		op_valid && kind == upper_state_pkg::OP_NARROW3
		|=> !upper_nonzero[$past(op_dest)])
		else $error("narrow op left upper bits");
	clear_all_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		op_valid && kind == upper_state_pkg::OP_UPCLEAR
		|=> cur == upper_state_pkg::ST_CLEAN && upper_nonzero == 16'h0)
		else $error("upper clear failed");
	restore_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		op_valid && kind == upper_state_pkg::OP_RESTORE && restore_dirty
		|=> cur == upper_state_pkg::ST_PRESERVED
		&& penalty_type == `PEN_C) else $error("dirty restore wrong");
	legacy_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		op_valid && kind == upper_state_pkg::OP_LEGACY
		|=> $stable(upper_nonzero)) else $error("legacy touched upper");
	pulse_once_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		penalty_valid && !$past(op_valid) |-> 1'b0)
		else $error("penalty without op");
	merge_dep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		dep_valid |-> !full_copy && penalty_type == `PEN_A)
		else $error("merge variant copied");
	src_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		op_valid && (kind == upper_state_pkg::OP_NARROW3
		|| kind == upper_state_pkg::OP_WIDE3)
		&& op_src_a != op_dest && op_src_b != op_dest
		|=> upper_nonzero[$past(op_src_a)] == $past(upper_nonzero[op_src_a])
		&& upper_nonzero[$past(op_src_b)] == $past(upper_nonzero[op_src_b]))
		else $error("source register changed");
	base_pen_b_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		op_valid && (kind == upper_state_pkg::OP_NARROW3
		|| kind == upper_state_pkg::OP_WIDE3)
		&& cur == upper_state_pkg::ST_PRESERVED && !merge_variant
		|=> penalty_valid && penalty_type == `PEN_B && full_copy)
		else $error("type B penalty missing");
	upclear_pen_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		op_valid && kind == upper_state_pkg::OP_UPCLEAR
		&& cur == upper_state_pkg::ST_PRESERVED && !merge_variant
		|=> penalty_valid && penalty_type == `PEN_D)
		else $error("type D penalty missing");
	clean_restore_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		op_valid && kind == upper_state_pkg::OP_RESTORE && !restore_dirty
		|=> cur == upper_state_pkg::ST_CLEAN && !penalty_valid
		&& upper_nonzero == 16'h0)
		else $error("clean restore wrong");
	merge_no_b_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		op_valid && (kind == upper_state_pkg::OP_NARROW3
		|| kind == upper_state_pkg::OP_WIDE3) && merge_variant
		|=> !penalty_valid && !full_copy && !dep_valid)
		else $error("merge three-operand penalised");
endmodule
`default_nettype wire

// *** design/upper_state_map.svh ***
`ifndef UPPER_STATE_MAP_SVH
`define UPPER_STATE_MAP_SVH
`define NUM_VREGS      16
`define VREG_IDX_W     4
`define UPPER_W        128
`define LOWER_W        128
`define STATE_RESET    2'h0
`define PEN_NONE       3'h0
`define PEN_A          3'h1
`define PEN_B          3'h2
`define PEN_C          3'h3
`define PEN_D          3'h4
`endif

// *** design/upper_state_pkg.sv ***
package upper_state_pkg;
	typedef enum logic [1:0]
	{
		ST_CLEAN     = 2'h0,
		ST_MODIFIED  = 2'h1,
		ST_PRESERVED = 2'h2
	} upper_state_t;
	typedef enum logic [2:0]
	{
		OP_NONE      = 3'h0,
		OP_LEGACY    = 3'h1,
		OP_NARROW3   = 3'h2,
		OP_WIDE3     = 3'h3,
		OP_UPCLEAR   = 3'h4,
		OP_RESTORE   = 3'h5
	} op_kind_t;
	typedef enum logic [2:0]
	{
		PEN_NONE_T = 3'h0,
		PEN_A_T    = 3'h1,
		PEN_B_T    = 3'h2,
		PEN_C_T    = 3'h3,
		PEN_D_T    = 3'h4
	} penalty_t;
endpackage

// *** design/upper_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface upper_if;
	logic                    wr;
	logic [3:0]              idx;
	logic [127:0]            data;
	logic                    clear_all;
	logic [15:0]             nonzero;
	modport ctrl (output wr, output idx, output data, output clear_all,
		input nonzero);
	modport bank (input wr, input idx, input data, input clear_all,
		output nonzero);
endinterface
`default_nettype wire

// *** design/upper_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "upper_state_map.svh"
module upper_bank
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	upper_if.bank     u
);
	logic [`UPPER_W-1:0] bits [`NUM_VREGS];
	logic [`UPPER_W-1:0] next_bits [`NUM_VREGS];

	genvar g;
	generate
		for (g = 0; g < `NUM_VREGS; g++)
		begin : g_reg
			always_comb
			begin
				next_bits[g] = bits[g];
				if (u.clear_all)
					next_bits[g] = '0;
				else if (u.wr && u.idx == 4'(g))
					next_bits[g] = u.data;
			end
			always_ff @(posedge clk_sys or negedge rst_n)
			begin
				if (!rst_n)
					bits[g] <= '0;
				else
					bits[g] <= next_bits[g];
			end
			assign u.nonzero[g] = |bits[g];
		end
	endgenerate
endmodule
`default_nettype wire

// *** tb/issue_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// issue side driver
// ****************************************
module issue_model
(
	input  wire logic    clk_sys,
	output logic         merge_variant,
	output logic         op_valid,
	output logic [2:0]   op_kind,
	output logic [3:0]   op_dest,
	output logic [3:0]   op_src_a,
	output logic [3:0]   op_src_b,
	output logic [127:0] op_upper,
	output logic         restore_dirty
);
	initial
	begin
		{merge_variant, op_valid, op_kind, op_dest} = '0;
		{op_src_a, op_src_b, op_upper, restore_dirty} = '0;
	end
	task automatic issue(input logic m, input logic v, input logic [2:0] k,
		input logic [11:0] r, input logic [127:0] u, input logic dy);
		@(posedge clk_sys);
		#1;
		merge_variant = m;
		op_valid = v;
		op_kind = k;
		{op_dest, op_src_a, op_src_b} = r;
		op_upper = u;
		restore_dirty = dy;
	endtask
endmodule
`default_nettype wire

// *** tb/vector_upper_state_tracker_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// self-checking bench
// ****************************************
module vector_upper_state_tracker_test;
	logic clk_sys, rstn, mg, v, dy, pv, dv, fc;
	logic [2:0] k, pt;
	logic [3:0] d, sa, sb, dr;
	logic [1:0] st, est;
	logic [127:0] u;
	logic [15:0] nz, enz;
	logic [2:0] ep;
	logic [3:0] ed;
	logic emg, known;
	logic [31:0] r = 32'hF945A4B1;
	int failures = 0;
	int check_count = 0;
	logic [2:0] hand [10] = '{3'h3, 3'h1, 3'h1, 3'h3, 3'h1, 3'h2, 3'h5,
		3'h2, 3'h4, 3'h5};
	issue_model u_issue (.clk_sys(clk_sys), .merge_variant(mg),
		.op_valid(v), .op_kind(k), .op_dest(d), .op_src_a(sa),
		.op_src_b(sb), .op_upper(u), .restore_dirty(dy));
	vector_upper_state_tracker u_dut (.clk_sys(clk_sys), .rstn(rstn),
		.merge_variant(mg), .op_valid(v), .op_kind(k), .op_dest(d),
		.op_src_a(sa), .op_src_b(sb), .op_upper(u), .restore_dirty(dy),
		.state(st), .penalty_valid(pv), .penalty_type(pt), .dep_valid(dv),
		.dep_reg(dr), .full_copy(fc), .upper_nonzero(nz));
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [1:0] next_of(logic [1:0] s, logic [2:0] q,
		logic y);
		case (q)
			3'h1: return (s == 2'h1) ? 2'h2 : s;
			3'h2, 3'h3: return 2'h1;
			3'h4: return 2'h0;
			3'h5: return y ? 2'h2 : 2'h0;
			default: return s;
		endcase
	endfunction
	function automatic logic [2:0] pen_of(logic [1:0] s, logic [2:0] q,
		logic y, logic m);
		if (q == 3'h1 && s == 2'h1) return 3'h1;
		if ((q == 3'h2 || q == 3'h3) && s == 2'h2 && !m) return 3'h2;
		if (q == 3'h4 && s == 2'h2 && !m) return 3'h4;
		if (q == 3'h5 && y) return 3'h3;
		return 3'h0;
	endfunction
	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		check_count++;
		if (s !== e)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tally_and_finish;
		if (failures == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic step(logic m, logic w, logic [2:0] q, logic y,
		logic [127:0] x);
		r = lfsr(r);
		u_issue.issue(m, w, q, r[11:0], x, y);
		chk("state", est, st);
		chk("pulse", ep != 3'h0, pv);
		if (ep != 3'h0) chk("type", ep, pt);
		chk("copy", !emg && (ep == 3'h1 || ep == 3'h2), fc);
		chk("dep", emg && ep == 3'h1, dv);
		if (emg && ep == 3'h1) chk("dep_reg", ed, dr);
		if (known) chk("nonzero", enz, nz);
		ep = w ? pen_of(est, q, y, m) : 3'h0;
		emg = m;
		ed = r[11:8];
		if (w)
		begin
			est = next_of(est, q, y);
			if (q == 3'h2) enz[ed] = 1'b0;
			if (q == 3'h3) enz[ed] = |x;
			if (q == 3'h4 || (q == 3'h5 && !y)) {known, enz} = {1'b1, 16'h0};
			if (q == 3'h5 && y) known = 1'b0;
		end
	endtask
	task automatic do_reset;
		rstn = 1'b0;
		u_issue.issue(1'b0, 1'b0, 3'h0, 12'h0, 128'h0, 1'b0);
		repeat (19) @(posedge clk_sys);
		#1 rstn = 1'b1;
		repeat (2) @(posedge clk_sys);
		{est, enz, ep, emg, known} = {2'h0, 16'h0, 3'h0, 1'b0, 1'b1};
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial
	begin
		#20000 failures++;
		tally_and_finish();
	end
	initial
	begin
		do_reset();
		for (int j = 0; j < 20; j++)
			step(j >= 10, 1'b1, hand[j % 10], 1'b1, {j[0], 127'h0});
		for (int i = 0; i < 400; i++)
		begin
			r = lfsr(r);
			step(r[20], r[3] | r[4], r[2:0], r[9], r[8] ? 128'h0 : {4{r}});
		end
		do_reset();
		step(1'b0, 1'b0, 3'h0, 1'b0, 128'h0);
		step(1'b0, 1'b0, 3'h0, 1'b0, 128'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
